// ===== common/rtcm_pkg.sv
// Purpose: shared constants for the match counter and its fabric controller
// Assumes: one 10 MHz clock, byte-wide configuration port
// Notes:   group/byte addressing, controller word map, reset values

package rtcm_pkg;

   // ==========================================================
   // counter geometry
   localparam int unsigned CNT_W     = 40;
   localparam int unsigned CNT_BYTES = 5;
   localparam int unsigned PRESCALE  = 128;
   localparam int unsigned PRE_W     = 7;

   // ==========================================================
   // device byte map: addr[7:3] group, addr[2:0] byte index
   localparam logic [4:0] GRP_COUNT = 5'h00;
   localparam logic [4:0] GRP_MATCH = 5'h01;
   localparam logic [4:0] GRP_MBITS = 5'h02;
   localparam logic [4:0] GRP_CTRL  = 5'h03;
   localparam logic [2:0] LAST_BYTE = 3'h4;

   // control/status byte fields
   localparam int unsigned CTL_MODE_LSB  = 0;
   localparam int unsigned CTL_XTAL_BIT  = 2;
   localparam int unsigned CTL_AUTO_BIT  = 3;
   localparam int unsigned CTL_MATCH_BIT = 7;
   localparam logic [3:0]  CTRL_RST      = 4'h0;
   localparam logic [CNT_W-1:0] CNT_RST  = 40'h00_0000_0000;
   localparam logic [CNT_W-1:0] MATCH_RST = 40'h00_0000_0000;

   // ==========================================================
   // controller wishbone word map (byte addresses)
   localparam logic [7:0] WB_CMD      = 8'h00;
   localparam logic [7:0] WB_RDATA    = 8'h04;
   localparam logic [7:0] WB_IRQ_STAT = 8'h08;
   localparam logic [7:0] WB_IRQ_MASK = 8'h0c;
   localparam logic [7:0] WB_PINS     = 8'h10;

   // command word fields
   localparam int unsigned CMD_ADDR_LSB = 0;
   localparam int unsigned CMD_DATA_LSB = 8;
   localparam int unsigned CMD_WR_BIT   = 16;
   localparam int unsigned CMD_RD_BIT   = 17;

   // interrupt bits
   localparam int unsigned IRQ_W         = 2;
   localparam int unsigned IRQ_MATCH_BIT = 0;
   localparam int unsigned IRQ_RDONE_BIT = 1;
   localparam logic [1:0]  IRQ_RST       = 2'h0;

endpackage : rtcm_pkg

// ===== common/rtcm_if.sv
// Purpose: byte configuration port and pins between counter and fabric
// Assumes: both ends on clk; counter_clock_in driven by the oscillator model
// Notes:   fab issues one-cycle wr/rd strobes, dev answers rd with rvalid

`timescale 1ns/100ps

interface rtcm_if;
   logic [7:0] cfg_addr;              // byte address
   logic [7:0] cfg_wdata;             // write byte
   logic       cfg_wr;                // write strobe
   logic       cfg_rd;                // read strobe
   logic [7:0] cfg_rdata;             // read byte
   logic       cfg_rvalid;            // read answer strobe
   logic       counter_clock_in;      // oscillator clock output
   logic       match_flag;            // match to fabric
   logic       sequencer_match_flag;  // match to power sequencer
   logic [1:0] osc_mode_out;          // oscillator mode
   logic       osc_select_out;        // oscillator select

   modport dev (
      input  cfg_addr, cfg_wdata, cfg_wr, cfg_rd, counter_clock_in,
      output cfg_rdata, cfg_rvalid, match_flag, sequencer_match_flag,
      output osc_mode_out, osc_select_out
   );
   modport fab (
      output cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
      input  cfg_rdata, cfg_rvalid, match_flag, sequencer_match_flag,
      input  osc_mode_out, osc_select_out
   );
endinterface : rtcm_if

// ===== src/rtcm_prescaler.sv
// Purpose: divide a stream of edge pulses by a fixed ratio
// Assumes: edge_in is one-cycle pulse on clk
// Notes:   tick is a registered one-cycle pulse every PRESCALE edges

`timescale 1ns/100ps

module rtcm_prescaler import rtcm_pkg::*; (
   input  wire logic clk,      // system clock
   input  wire logic srst,     // sync reset
   input  wire logic edge_in,  // one rising edge seen
   output logic      tick      // divided enable pulse
);
   logic [PRE_W-1:0] cnt_r;
   logic [PRE_W-1:0] cnt_nxt;
   logic             tick_nxt;

   // =========================================================
   // edge counter
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (edge_in) begin
         cnt_nxt  = cnt_r + 1'b1;
         tick_nxt = (cnt_r == PRE_W'(PRESCALE - 1));
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule : rtcm_prescaler

// ===== src/rtcm_device.sv
// Purpose: 40-bit loadable match counter with byte configuration port
// Assumes: counter_clock_in is slow against clk and asynchronous to it
// Notes:   count, match and match-bits groups of five bytes each, control group of one byte
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.

`timescale 1ns/100ps

// Behaviour
// R1 - 40-bit loadable counter as time base
// R2 - counter clock only from oscillator output
// R3 - prescale by 128, count on divided clock
// R4 - written start value loads the counter
// R5 - count read back through holding register
// R6 - one byte per address, consecutive bytes
// R7 - match flag high exactly while equal
// R8 - sequencer match copy of match flag
// R9 - match bits all ones when equal
// R10 - auto clear to zero on match
// R11 - no auto clear when match zero
// R12 - mode output from control mode field
// R13 - select output from control enable bit
// R14 - snapshot all bytes on first byte read
module rtcm_device import rtcm_pkg::*; (
   input  wire logic clk,   // 10 MHz system clock
   input  wire logic srst,  // sync reset, active high
   rtcm_if.dev       port   // config port and pins
);
   // ==========================================================
   // oscillator clock synchroniser and edge detect
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic clk_rise;
   logic tick;

   // R2 sampled oscillator clock
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= port.counter_clock_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // rising edge of the synchronised level
   assign clk_rise = sync2_r & ~sync3_r;

   // R3 divide by 128
   rtcm_prescaler u_pre (
      .clk     (clk),
      .srst    (srst),
      .edge_in (clk_rise),
      .tick    (tick)
   );

   // ==========================================================
   // state
   logic [CNT_W-1:0] cnt_r,    cnt_nxt;
   logic [CNT_W-1:0] match_r,  match_nxt;
   logic [CNT_W-1:0] stage_r,  stage_nxt;
   logic [CNT_W-1:0] hold_r,   hold_nxt;
   logic [3:0]       ctrl_r,   ctrl_nxt;
   logic [7:0]       rdata_r,  rdata_nxt;
   logic             rvalid_r, rvalid_nxt;
   logic             mflag_r,  mflag_nxt;
   logic             sflag_r,  sflag_nxt;
   logic [1:0]       mode_r,   mode_nxt;
   logic             sel_r,    sel_nxt;

   // decode helpers
   logic [4:0]       grp;
   logic [2:0]       idx;
   logic [5:0]       lsb;
   logic             in_rng;
   logic             equal;
   logic             auto_clr;
   logic             load;
   logic [CNT_W-1:0] mbits;
   logic [CNT_W-1:0] load_val;

   assign grp    = port.cfg_addr[7:3];
   assign idx    = port.cfg_addr[2:0];
   assign lsb    = {idx, 3'b000};
   assign in_rng = (idx <= LAST_BYTE);

   // R7 live comparison
   assign equal = (cnt_r == match_r);
   // R9 bitwise agreement, all ones on match
   assign mbits = ~(cnt_r ^ match_r);
   // R11 clear only with a non-zero match value
   assign auto_clr = ctrl_r[CTL_AUTO_BIT] & equal & (match_r != MATCH_RST);

   // ==========================================================
   // register writes
   always_comb begin
      stage_nxt = stage_r;
      match_nxt = match_r;
      ctrl_nxt  = ctrl_r;
      load      = 1'b0;
      load_val  = stage_r;
      // R6 one byte per address
      if (port.cfg_wr && in_rng) begin
         if (grp == GRP_COUNT) begin
            stage_nxt[lsb +: 8] = port.cfg_wdata;
            // R4 last byte commits the preload
            if (idx == LAST_BYTE) begin
               load     = 1'b1;
               load_val = {port.cfg_wdata, stage_r[31:0]};
            end
         end else if (grp == GRP_MATCH) begin
            match_nxt[lsb +: 8] = port.cfg_wdata;
         end else if (grp == GRP_CTRL && idx == 3'h0) begin
            ctrl_nxt = port.cfg_wdata[3:0];
         end
      end
   end

   // ==========================================================
   // counter
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         // R4 preload wins over everything
         cnt_nxt = load_val;
      end else if (auto_clr) begin
         // R10 clear on match
         cnt_nxt = CNT_RST;
      end else if (tick) begin
         // R1 advance on divided clock
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // read port
   always_comb begin
      hold_nxt   = hold_r;
      rdata_nxt  = 8'h00;
      rvalid_nxt = port.cfg_rd;
      if (port.cfg_rd && in_rng) begin
         if (grp == GRP_COUNT) begin
            if (idx == 3'h0) begin
               // R14 snapshot on first byte
               hold_nxt  = cnt_r;
               rdata_nxt = cnt_r[7:0];
            end else begin
               // R5 later bytes from the hold
               rdata_nxt = hold_r[lsb +: 8];
            end
         end else if (grp == GRP_MATCH) begin
            rdata_nxt = match_r[lsb +: 8];
         end else if (grp == GRP_MBITS) begin
            // R9 match bits readback
            rdata_nxt = mbits[lsb +: 8];
         end else if (grp == GRP_CTRL && idx == 3'h0) begin
            rdata_nxt = {mflag_r, 3'h0, ctrl_r};
         end
      end
   end

   // ==========================================================
   // output pins
   always_comb begin
      // R7 flag follows equality
      mflag_nxt = equal;
      // R8 identical sequencer copy
      sflag_nxt = equal;
      // R12 mode field to oscillator
      mode_nxt  = ctrl_r[CTL_MODE_LSB +: 2];
      // R13 enable bit to oscillator select
      sel_nxt   = ctrl_r[CTL_XTAL_BIT];
   end

   // register all state
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r    <= CNT_RST;
         match_r  <= MATCH_RST;
         stage_r  <= CNT_RST;
         hold_r   <= CNT_RST;
         ctrl_r   <= CTRL_RST;
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
         mflag_r  <= 1'b0;
         sflag_r  <= 1'b0;
         mode_r   <= 2'h0;
         sel_r    <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         match_r  <= match_nxt;
         stage_r  <= stage_nxt;
         hold_r   <= hold_nxt;
         ctrl_r   <= ctrl_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         mflag_r  <= mflag_nxt;
         sflag_r  <= sflag_nxt;
         mode_r   <= mode_nxt;
         sel_r    <= sel_nxt;
      end
   end

   assign port.cfg_rdata            = rdata_r;
   assign port.cfg_rvalid           = rvalid_r;
   assign port.match_flag           = mflag_r;
   assign port.sequencer_match_flag = sflag_r;
   assign port.osc_mode_out         = mode_r;
   assign port.osc_select_out       = sel_r;

endmodule : rtcm_device

// ===== src/rtcm_fabric.sv
// Purpose: fabric controller that drives the counter's byte port
// Assumes: classic wishbone slave on clk, counter end on same clk
// Notes:   one byte access per command, match rise raises interrupt

`timescale 1ns/100ps

module rtcm_fabric import rtcm_pkg::*; (
   input  wire logic        clk,       // 10 MHz system clock
   input  wire logic        srst,      // sync reset, active high
   input  wire logic        wb_cyc_i,  // bus cycle
   input  wire logic        wb_stb_i,  // strobe
   input  wire logic        wb_we_i,   // write enable
   input  wire logic [7:0]  wb_adr_i,  // byte address
   input  wire logic [3:0]  wb_sel_i,  // byte lanes
   input  wire logic [31:0] wb_dat_i,  // write data
   output logic      [31:0] wb_dat_o,  // read data
   output logic             wb_ack_o,  // acknowledge
   output logic             irq,       // level interrupt
   rtcm_if.fab              port       // counter side
);
   typedef enum {FB_IDLE, FB_READ} rtcm_fstate_e;

   rtcm_fstate_e st_r, st_nxt;
   logic [7:0]   addr_r,  addr_nxt;
   logic [7:0]   wdat_r,  wdat_nxt;
   logic         wr_r,    wr_nxt;
   logic         rd_r,    rd_nxt;
   logic [7:0]   rbyte_r, rbyte_nxt;
   logic [1:0]   stat_r,  stat_nxt;
   logic [1:0]   mask_r,  mask_nxt;
   logic         mprev_r, mprev_nxt;
   logic         irq_nxt;
   logic         ack_nxt;
   logic [31:0]  dat_nxt;
   logic         req;
   logic         wr_cmd;
   logic [1:0]   events;

   // new request, one answer per cycle
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_cmd = req & wb_we_i & (wb_adr_i == WB_CMD) & (st_r == FB_IDLE);

   // ==========================================================
   // bus, command and interrupt next state
   always_comb begin
      st_nxt    = st_r;
      addr_nxt  = addr_r;
      wdat_nxt  = wdat_r;
      wr_nxt    = 1'b0;
      rd_nxt    = 1'b0;
      rbyte_nxt = rbyte_r;
      mask_nxt  = mask_r;
      mprev_nxt = port.match_flag;
      ack_nxt   = req;
      dat_nxt   = 32'h0000_0000;
      events    = 2'h0;
      events[IRQ_MATCH_BIT] = port.match_flag & ~mprev_r;
      events[IRQ_RDONE_BIT] = port.cfg_rvalid;
      stat_nxt  = stat_r;
      // command issue, refused while a read is pending
      if (wr_cmd && wb_sel_i[2]) begin
         if (wb_sel_i[0]) addr_nxt = wb_dat_i[CMD_ADDR_LSB +: 8];
         if (wb_sel_i[1]) wdat_nxt = wb_dat_i[CMD_DATA_LSB +: 8];
         if (wb_dat_i[CMD_RD_BIT]) begin
            rd_nxt = 1'b1;
            st_nxt = FB_READ;
         end else begin
            wr_nxt = wb_dat_i[CMD_WR_BIT];
         end
      end
      // read answer capture
      case (st_r)
         FB_IDLE: begin
         end
         FB_READ: begin
            if (port.cfg_rvalid) begin
               rbyte_nxt = port.cfg_rdata;
               st_nxt    = FB_IDLE;
            end
         end
         default: st_nxt = FB_IDLE;
      endcase
      // register access decode
      if (req && wb_adr_i == WB_CMD) begin
         dat_nxt = {14'h0000, st_r == FB_READ, 1'b0, wdat_r, addr_r};
      end else if (req && wb_adr_i == WB_RDATA) begin
         dat_nxt = {24'h00_0000, rbyte_r};
      end else if (req && wb_adr_i == WB_IRQ_STAT) begin
         dat_nxt = {30'h0000_0000, stat_r};
         if (!wb_we_i) stat_nxt = IRQ_RST;
      end else if (req && wb_adr_i == WB_IRQ_MASK) begin
         dat_nxt = {30'h0000_0000, mask_r};
         if (wb_we_i && wb_sel_i[0]) mask_nxt = wb_dat_i[1:0];
      end else if (req && wb_adr_i == WB_PINS) begin
         dat_nxt = {27'h000_0000, port.osc_select_out, port.osc_mode_out,
                    port.sequencer_match_flag, port.match_flag};
      end
      if (!req || wb_we_i) dat_nxt = 32'h0000_0000;
      // set wins over read clear
      stat_nxt = stat_nxt | events;
      irq_nxt  = |(stat_nxt & mask_nxt);
   end

   // register all state
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r     <= FB_IDLE;
         addr_r   <= 8'h00;
         wdat_r   <= 8'h00;
         wr_r     <= 1'b0;
         rd_r     <= 1'b0;
         rbyte_r  <= 8'h00;
         stat_r   <= IRQ_RST;
         mask_r   <= IRQ_RST;
         mprev_r  <= 1'b0;
         irq      <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         st_r     <= st_nxt;
         addr_r   <= addr_nxt;
         wdat_r   <= wdat_nxt;
         wr_r     <= wr_nxt;
         rd_r     <= rd_nxt;
         rbyte_r  <= rbyte_nxt;
         stat_r   <= stat_nxt;
         mask_r   <= mask_nxt;
         mprev_r  <= mprev_nxt;
         irq      <= irq_nxt;
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
      end
   end

   assign port.cfg_addr  = addr_r;
   assign port.cfg_wdata = wdat_r;
   assign port.cfg_wr    = wr_r;
   assign port.cfg_rd    = rd_r;

endmodule : rtcm_fabric

// ===== verification/rtcm_monitor.sv
// Purpose: concurrent checks on the counter's byte port and pins
// Assumes: one clock, sync reset, watched beside the interface
// Notes:   shadow regs track match value and auto clear bit
`timescale 1ns/100ps

module rtcm_monitor import rtcm_pkg::*; (
   input wire logic       clk,                  // clock
   input wire logic       srst,                 // sync reset
   input wire logic [7:0] cfg_addr,             // byte address
   input wire logic [7:0] cfg_wdata,            // write byte
   input wire logic       cfg_wr,               // write strobe
   input wire logic       cfg_rd,               // read strobe
   input wire logic [7:0] cfg_rdata,            // read byte
   input wire logic       cfg_rvalid,           // read answer
   input wire logic       match_flag,           // match to fabric
   input wire logic       sequencer_match_flag, // match copy
   input wire logic [1:0] osc_mode_out,         // oscillator mode
   input wire logic       osc_select_out        // oscillator select
);
   // ==========================================================
   // shadow state
   logic [CNT_W-1:0] mt_r, mt_nxt;
   logic             auto_r, auto_nxt;
   logic [1:0]       mode_w;
   logic             sel_w;

   assign mode_w = cfg_wdata[1:0];
   assign sel_w  = cfg_wdata[CTL_XTAL_BIT];

   // next match value and auto bit from port writes
   always_comb begin
      mt_nxt   = mt_r;
      auto_nxt = auto_r;
      if (cfg_wr && cfg_addr[7:3] == GRP_MATCH && cfg_addr[2:0] <= LAST_BYTE) begin
         mt_nxt[cfg_addr[2:0]*8 +: 8] = cfg_wdata;
      end
      if (cfg_wr && cfg_addr == {GRP_CTRL, 3'h0}) begin
         auto_nxt = cfg_wdata[CTL_AUTO_BIT];
      end
   end

   // register shadow state
   always_ff @(posedge clk) begin
      if (srst) begin
         mt_r   <= MATCH_RST;
         auto_r <= 1'b0;
      end else begin
         mt_r   <= mt_nxt;
         auto_r <= auto_nxt;
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read strobe not answered");
   AST_ANSWER_CAUSE: assert property (cfg_rvalid |-> $past(cfg_rd))
      else $error("read answer without strobe");
   AST_RDATA_IDLE: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00)
      else $error("read byte not zero outside answer");
   AST_RSVD_ZERO: assert property (cfg_rd && cfg_addr[2:0] > LAST_BYTE |=> cfg_rdata == 8'h0)
      else $error("unused byte index read not zero");
   AST_SEQ_COPY: assert property (sequencer_match_flag == match_flag)
      else $error("sequencer match differs from match");
   AST_MODE_OUT: assert property (cfg_wr && cfg_addr == {GRP_CTRL, 3'h0}
      |-> ##2 osc_mode_out == $past(mode_w, 2))
      else $error("mode output not from control write");
   AST_SEL_OUT: assert property (cfg_wr && cfg_addr == {GRP_CTRL, 3'h0}
      |-> ##2 osc_select_out == $past(sel_w, 2))
      else $error("select output not from control write");
   AST_MBITS_ONES: assert property ((cfg_rd && cfg_addr[7:3] == GRP_MBITS
      && cfg_addr[2:0] <= LAST_BYTE ##1 match_flag [*2]) |-> $past(cfg_rdata) == 8'hff)
      else $error("match bits not all ones on equality");
   AST_AUTO_PULSE: assert property (match_flag && auto_r && mt_r != '0 && !cfg_wr
      && !$past(cfg_wr) |=> !match_flag)
      else $error("auto clear did not end the match");
endmodule : rtcm_monitor

// ===== verification/rtcm_match_counter_tb.sv
// Purpose: self-checking bench for fabric controller and counter
// Assumes: wishbone master on clk, oscillator toggled by the bench
// Notes:   each read pushes an expected word and mask; a watcher compares
`timescale 1ns/100ps

module rtcm_match_counter_tb import rtcm_pkg::*; ();
   typedef struct packed { logic [31:0] v; logic [31:0] m; } rtcm_exp_s;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic [39:0] cnt_m, mt_m, c;
   logic [31:0] stg;
   logic [3:0]  ctl_m;
   int          n_fail = 0;
   int          samples_checked = 0;
   rtcm_exp_s   expq[$];
   rtcm_exp_s   e;

   rtcm_if bus ();
   rtcm_device u_rtcm_device (.clk(clk), .srst(srst), .port(bus));
   rtcm_fabric u_rtcm_fabric (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .port(bus));
   rtcm_monitor u_rtcm_monitor (.clk(clk), .srst(srst), .cfg_addr(bus.cfg_addr),
      .cfg_wdata(bus.cfg_wdata), .cfg_wr(bus.cfg_wr), .cfg_rd(bus.cfg_rd),
      .cfg_rdata(bus.cfg_rdata), .cfg_rvalid(bus.cfg_rvalid), .match_flag(bus.match_flag),
      .sequencer_match_flag(bus.sequencer_match_flag), .osc_mode_out(bus.osc_mode_out),
      .osc_select_out(bus.osc_select_out));

   // ==========================================================
   // clock and helpers
   always #50 clk = ~clk;

   task automatic finish_test();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] ev, input logic [31:0] em, input logic [31:0] g);
      samples_checked++;
      if (((g ^ ev) & em) !== 32'h0) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, ev);
      end
   endtask : chk

   // classic wishbone single cycle, bounded wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_sel_i <= 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk);
      if (i == 20) begin
         n_fail++;
         finish_test();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] em);
      expq.push_back({ev, em});
      wb(1'b0, a, 32'h0);
   endtask : rd

   // device byte write plus model update
   task automatic dw(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, WB_CMD, {15'h0, 1'b1, d, a});
      if (a[7:3] == GRP_COUNT && a[2:0] < LAST_BYTE) stg[a[2:0]*8 +: 8] = d;
      if (a == {GRP_COUNT, LAST_BYTE}) cnt_m = {d, stg};
      if (a[7:3] == GRP_MATCH && a[2:0] <= LAST_BYTE) mt_m[a[2:0]*8 +: 8] = d;
      if (a == {GRP_CTRL, 3'h0}) ctl_m = d[3:0];
   endtask : dw

   task automatic dr(input logic [7:0] a, input logic [7:0] ev);
      wb(1'b1, WB_CMD, {14'h0000, 1'b1, 1'b0, 8'h00, a});
      rd(WB_RDATA, {24'h0, ev}, 32'hffff_ffff);
   endtask : dr

   task automatic put(input logic [4:0] g, input logic [39:0] v);
      for (int k = 0; k < 5; k++) dw({g, k[2:0]}, v[k*8 +: 8]);
   endtask : put

   task automatic crd(input logic [39:0] v);
      for (int k = 0; k < 5; k++) dr({GRP_COUNT, k[2:0]}, v[k*8 +: 8]);
   endtask : crd

   // only the oscillator model drives the counter clock
   task automatic osc(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk);
         bus.counter_clock_in <= 1'b1;
         repeat (3) @(posedge clk);
         bus.counter_clock_in <= 1'b0;
      end
      repeat (10) @(posedge clk);
   endtask : osc

   function automatic logic [31:0] pins_e();
      logic eq;
      eq = (cnt_m == mt_m);
      return {27'h0, ctl_m[2], ctl_m[1:0], eq, eq};
   endfunction : pins_e

   // watcher: each read answer takes the oldest note
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (expq.size() == 0) begin
            n_fail++;
            $display("BAD %0t read without note", $time);
         end else begin
            e = expq.pop_front();
            chk(e.v, e.m, wb_dat_o);
         end
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hf;
      bus.counter_clock_in = 1'b0;
      {cnt_m, mt_m, stg, ctl_m} = '0;
      r = $urandom(32'h0000f9c2);
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd(WB_PINS, pins_e(), 32'hffff_ffff);
      rd(WB_IRQ_MASK, 32'h0, 32'hffff_ffff);
      wb(1'b1, 8'h14, 32'hffff_ffff);
      rd(8'h14, 32'h0, 32'hffff_ffff);
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         dw(8'h18, {5'h0, r[0], k[1:0]});
         rd(WB_PINS, pins_e(), 32'hffff_ffff);
         dr(8'h18, {(cnt_m == mt_m), 3'h0, ctl_m});
      end
      r = $urandom;
      c = {1'b0, r[6:0], $urandom};
      for (int k = 0; k < 4; k++) dw({GRP_COUNT, k[2:0]}, c[k*8 +: 8]);
      crd(cnt_m);
      dr({GRP_COUNT, 3'h0}, cnt_m[7:0]);
      dw({GRP_COUNT, LAST_BYTE}, c[39:32]);
      for (int k = 1; k < 5; k++) dr({GRP_COUNT, k[2:0]}, 8'h00);
      crd(c);
      dr({GRP_COUNT, 3'h5}, 8'h00);
      wb(1'b1, WB_IRQ_MASK, 32'h1);
      rd(WB_IRQ_STAT, 32'h0, 32'h0);
      put(GRP_MATCH, cnt_m);
      rd(WB_PINS, pins_e(), 32'hffff_ffff);
      chk(32'h1, 32'h1, {31'h0, irq});
      for (int k = 0; k < 5; k++) dr({GRP_MBITS, k[2:0]}, 8'hff);
      rd(WB_IRQ_STAT, 32'h3, 32'h3);
      repeat (3) @(posedge clk);
      chk(32'h0, 32'h1, {31'h0, irq});
      dw({GRP_MATCH, 3'h0}, ~c[7:0]);
      dr({GRP_MBITS, 3'h0}, ~(cnt_m[7:0] ^ mt_m[7:0]));
      rd(WB_PINS, pins_e(), 32'hffff_ffff);
      put(GRP_MATCH, c + 40'h1);
      dw(8'h18, 8'h08);
      rd(WB_IRQ_STAT, 32'h0, 32'h0);
      osc(127);
      crd(c);
      osc(1);
      cnt_m = '0;
      crd(cnt_m);
      rd(WB_IRQ_STAT, 32'h3, 32'h3);
      put(GRP_MATCH, 40'h0);
      put(GRP_COUNT, 40'h0);
      rd(WB_PINS, pins_e(), 32'hffff_ffff);
      osc(128);
      cnt_m = 40'h1;
      crd(cnt_m);
      rd(WB_PINS, pins_e(), 32'hffff_ffff);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule : rtcm_match_counter_tb
